// File: rtl/rrs_pkg.sv
// Purpose: shared constants and types of the rolling readout sequencer
// Assumes: 12-bit register words loaded through a parallel address/data port
// Notes:   register indices are word indices of the upload port
package rrs_pkg;

   // register word width and upload address width
   localparam int unsigned REG_W  = 12;
   localparam int unsigned ADDR_W = 4;

   // register indices
   localparam logic [3:0] IDX_SEQUENCER   = 4'h0;
   localparam logic [3:0] IDX_PIXELS      = 4'h1;
   localparam logic [3:0] IDX_LINES       = 4'h2;
   localparam logic [3:0] IDX_INT_LINES   = 4'h3;
   localparam logic [3:0] IDX_SYNC_DELAY  = 4'h4;
   localparam logic [3:0] IDX_COL_START   = 4'h5;
   localparam logic [3:0] IDX_ROW_START   = 4'h6;
   localparam logic [3:0] IDX_CORE        = 4'h7;
   localparam logic [3:0] IDX_AMP         = 4'h8;
   localparam logic [3:0] IDX_COARSE_DAC  = 4'h9;
   localparam logic [3:0] IDX_FINE_DAC    = 4'ha;
   localparam logic [3:0] IDX_DARK_DAC    = 4'hb;
   localparam int unsigned NUM_REGS       = 12;

   // reset values
   localparam logic [11:0] RST_ZERO     = 12'h000;
   localparam logic [11:0] RST_FINE_DAC = 12'h080;

   // sequencer register fields
   localparam int unsigned SEQ_NDR_BIT   = 0;
   localparam int unsigned SEQ_MODE2_BIT = 2;

   // delay register fields
   localparam int unsigned DLY_PV_LSB  = 0;
   localparam int unsigned DLY_END_LSB = 4;
   localparam int unsigned DLY_W       = 4;
   localparam int unsigned DLY_DEPTH   = 13;
   localparam logic [3:0]  DLY_OFFSET  = 4'h2;

   // core register fields
   localparam int unsigned CORE_TEST_LSB = 0;
   localparam int unsigned CORE_HSUB_LSB = 2;
   localparam int unsigned CORE_VSUB_LSB = 5;

   // amplifier register fields
   localparam int unsigned AMP_GAIN_LSB  = 0;
   localparam int unsigned AMP_UNITY_BIT = 4;
   localparam int unsigned AMP_ONE_BIT   = 5;
   localparam int unsigned AMP_STBY_BIT  = 6;
   localparam int unsigned AMP_CLKD_LSB  = 7;
   localparam int unsigned AMP_CLKD_INV  = 9;

   // last allowed window start positions
   localparam logic [11:0] COL_START_MAX = 12'h062;
   localparam logic [11:0] ROW_START_MAX = 12'h089;

   // row blanking in system clock cycles
   localparam int unsigned ROW_BLANK_CYC = 282;

   // upload port word
   typedef struct packed {
      logic             load;
      logic [3:0]       addr;
      logic [11:0]      data;
   } rrs_reg_wr_t;

   // static settings toward the analog core
   typedef struct packed {
      logic [1:0] core_test;
      logic [2:0] hsub_mode;
      logic [2:0] vsub_mode;
      logic [3:0] amp_gain;
      logic       amp_unity;
      logic       one_output;
      logic       second_path_standby;
      logic       amp_standby;
      logic [2:0] amp_clk_delay;
      logic       amp_clk_invert;
      logic [7:0] coarse_dac;
      logic [7:0] fine_dac;
      logic [7:0] dark_dac;
      logic       dark_on_reset_bus;
      logic [11:0] col_start;
      logic [11:0] row_start;
   } rrs_analog_t;

   // line sequencing states
   typedef enum logic [1:0] {
      LS_IDLE  = 2'b00,
      LS_BLANK = 2'b01,
      LS_READ  = 2'b11
   } rrs_line_state_t;

   // reset value of a register word
   function automatic logic [11:0] reg_reset(input int unsigned idx);
      reg_reset = (idx == int'(IDX_FINE_DAC)) ? RST_FINE_DAC : RST_ZERO;
   endfunction

   // delay code to added cycles: none up to 2, code minus 2 above
   function automatic logic [3:0] delay_cycles(input logic [3:0] code);
      delay_cycles = (code > DLY_OFFSET) ? code - DLY_OFFSET : 4'h0;
   endfunction

endpackage

// File: rtl/rrs_delay_line.sv
// Purpose: tapped shift line giving a selectable delay in system clocks
// Assumes: tap 0 passes the input straight through
// Notes:   the caller registers the output
`timescale 1ns/10ps
module rrs_delay_line #(
   parameter int unsigned W     = 1,
   parameter int unsigned DEPTH = rrs_pkg::DLY_DEPTH
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_data,
   input  wire logic [3:0]   i_tap,
   output logic [W-1:0]      o_data
);

   logic [W-1:0] stage [0:DEPTH];

   assign stage[0] = i_data;

   // one flop per delay step
   genvar g;
   generate
      for (g = 1; g <= DEPTH; g++) begin : g_stage
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               stage[g] <= '0;
            end else begin
               stage[g] <= stage[g-1];
            end
         end
      end
   endgenerate

   // tap select, out of range taps use the last stage
   always_comb begin
      if (int'(i_tap) > DEPTH) begin
         o_data = stage[DEPTH];
      end else begin
         o_data = stage[i_tap];
      end
   end

endmodule

// File: rtl/rrs_sequencer.sv
// Purpose: readout sequencer of a rolling shutter sensor: pixel, line and
//          integration counters, row pointer syncs, delays and settings
// Assumes: row and frame pulses are level inputs synchronous to i_sys_clk
// Notes:   all outputs are registered
`timescale 1ns/10ps
module rrs_sequencer #(
   parameter int unsigned BLANK_CYC = rrs_pkg::ROW_BLANK_CYC,
   parameter int unsigned CW        = rrs_pkg::REG_W
) (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_rst_n,
   input  wire rrs_pkg::rrs_reg_wr_t i_reg_wr,
   input  wire logic                 i_row_clk,
   input  wire logic                 i_frame_start,
   output logic                      o_pixel_valid,
   output logic                      o_line_end_pulse,
   output logic                      o_frame_end,
   output logic                      o_left_row_sync,
   output logic                      o_right_row_sync,
   output logic [CW-1:0]             o_left_row_ptr,
   output logic [CW-1:0]             o_right_row_ptr,
   output logic [CW-1:0]             o_line_count,
   output logic [CW-1:0]             o_int_count,
   output logic [CW-1:0]             o_pixel_count,
   output logic [CW:0]               o_int_time_a,
   output logic [CW:0]               o_int_time_b,
   output rrs_pkg::rrs_analog_t      o_analog
);

   logic [CW-1:0]            regs [0:rrs_pkg::NUM_REGS-1];
   logic                     row_q;
   logic                     fs_q;
   logic                     row_pulse;
   logic                     fs_pulse;
   logic                     nondestructive_read;
   logic                     mode2;
   logic                     row_phase;
   logic                     advance;
   logic                     frame_open;
   logic                     right_done;
   logic                     frame_done;
   rrs_pkg::rrs_line_state_t state;
   logic [15:0]              blank_cnt;
   logic                     px_tick;
   logic [CW-1:0]            pixel_cnt;
   logic [CW-1:0]            line_cnt;
   logic [CW-1:0]            int_cnt;
   logic                     pv_raw;
   logic                     pv_fall;
   logic                     eol_pre;
   logic                     eol_raw;
   logic                     eof_raw;
   logic                     pv_dly;
   logic [1:0]               end_dly;
   logic [CW-1:0]            pixels_per_row;
   logic [CW-1:0]            lines_per_frame;
   logic [CW-1:0]            int_lines;
   logic [CW-1:0]            amp_reg;
   logic [CW-1:0]            core_reg;

   // named views of the register words
   assign pixels_per_row      = regs[rrs_pkg::IDX_PIXELS];
   assign lines_per_frame     = regs[rrs_pkg::IDX_LINES];
   assign int_lines           = regs[rrs_pkg::IDX_INT_LINES];
   assign amp_reg             = regs[rrs_pkg::IDX_AMP];
   assign core_reg            = regs[rrs_pkg::IDX_CORE];
   assign nondestructive_read = regs[rrs_pkg::IDX_SEQUENCER][rrs_pkg::SEQ_NDR_BIT];
   assign mode2               = nondestructive_read
                                & regs[rrs_pkg::IDX_SEQUENCER][rrs_pkg::SEQ_MODE2_BIT];

   // register upload, effective at once
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < rrs_pkg::NUM_REGS; k++) begin
            regs[k] <= rrs_pkg::reg_reset(k);
         end
      end else if (i_reg_wr.load && (int'(i_reg_wr.addr) < rrs_pkg::NUM_REGS)) begin
         regs[i_reg_wr.addr] <= i_reg_wr.data;
      end
   end

   // edge detect of the controller pulses
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         row_q <= 1'b0;
         fs_q  <= 1'b0;
      end else begin
         row_q <= i_row_clk;
         fs_q  <= i_frame_start;
      end
   end

   // each pulse is counted once however long it is held
   assign row_pulse = i_row_clk & ~row_q;
   assign fs_pulse  = i_frame_start & ~fs_q;

   // pair phase, 1 after the left row, 0 after the right row
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         row_phase <= 1'b0;
      end else if (fs_pulse) begin
         row_phase <= 1'b0;
      end else if (row_pulse && mode2) begin
         row_phase <= ~row_phase;
      end
   end

   // in mode 2 counters step on the second pulse of each pair
   assign advance = row_pulse & (~mode2 | row_phase);

   // frame bookkeeping
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frame_open <= 1'b0;
      end else if (fs_pulse) begin
         frame_open <= 1'b1;
      end else if (eof_raw) begin
         frame_open <= 1'b0;
      end
   end

   // line sequencing: blanking then pixel readout
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state     <= rrs_pkg::LS_IDLE;
         blank_cnt <= '0;
      end else if (row_pulse) begin
         state     <= rrs_pkg::LS_BLANK;
         blank_cnt <= 16'(BLANK_CYC - 1);
      end else begin
         unique case (state)
            rrs_pkg::LS_IDLE: begin
               blank_cnt <= '0;
            end
            rrs_pkg::LS_BLANK: begin
               if (blank_cnt == '0) begin
                  state <= rrs_pkg::LS_READ;
               end else begin
                  blank_cnt <= blank_cnt - 16'h0001;
               end
            end
            rrs_pkg::LS_READ: begin
               if (pv_fall) begin
                  state <= rrs_pkg::LS_IDLE;
               end
            end
            default: begin
               state <= rrs_pkg::LS_IDLE;
            end
         endcase
      end
   end

   // internal pixel clock at half the system rate
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         px_tick <= 1'b0;
      end else if (state != rrs_pkg::LS_READ) begin
         px_tick <= 1'b0;
      end else begin
         px_tick <= ~px_tick;
      end
   end

   assign pv_fall = pv_raw & px_tick & (pixel_cnt == pixels_per_row);

   // pixel-valid and pixel counter
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pv_raw    <= 1'b0;
         pixel_cnt <= '0;
      end else if (row_pulse) begin
         pv_raw    <= 1'b0;
         pixel_cnt <= '0;
      end else if (state == rrs_pkg::LS_BLANK && blank_cnt == '0) begin
         pv_raw    <= 1'b1;
         pixel_cnt <= '0;
      end else if (pv_fall) begin
         pv_raw <= 1'b0;
      end else if (pv_raw && px_tick) begin
         pixel_cnt <= pixel_cnt + 12'h001;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         line_cnt <= '0;
      end else if (fs_pulse) begin
         line_cnt <= '0;
      end else if (advance && frame_open && line_cnt != lines_per_frame) begin
         line_cnt <= line_cnt + 12'h001;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         int_cnt          <= '0;
         right_done       <= 1'b0;
         o_right_row_sync <= 1'b0;
      end else if (fs_pulse) begin
         int_cnt          <= '0;
         right_done       <= 1'b0;
         o_right_row_sync <= 1'b0;
      end else begin
         o_right_row_sync <= 1'b0;
         if (frame_open && !right_done && int_cnt == int_lines) begin
            o_right_row_sync <= 1'b1;
            right_done       <= 1'b1;
         end else if (advance && frame_open && !right_done) begin
            // stepped by the halved advance in mode 2
            int_cnt <= int_cnt + 12'h001;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_left_row_sync <= 1'b0;
      end else begin
         o_left_row_sync <= fs_pulse;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_left_row_ptr <= '0;
      end else if (fs_pulse) begin
         o_left_row_ptr <= o_analog.row_start;
      end else if (row_pulse && (!mode2 || !row_phase)) begin
         o_left_row_ptr <= o_left_row_ptr + 12'h001;
      end
   end

   // right pointer load at right sync, then shift
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_right_row_ptr <= '0;
      end else if (frame_open && !right_done && int_cnt == int_lines && !fs_pulse) begin
         o_right_row_ptr <= o_analog.row_start;
      end else if (row_pulse && (!mode2 || row_phase)) begin
         o_right_row_ptr <= o_right_row_ptr + 12'h001;
      end
   end

   // line end one clock after the fall, frame end with the fall
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         eol_pre    <= 1'b0;
         eol_raw    <= 1'b0;
         eof_raw    <= 1'b0;
         frame_done <= 1'b0;
      end else begin
         eol_pre <= pv_fall;
         eol_raw <= eol_pre;
         eof_raw <= 1'b0;
         if (fs_pulse) begin
            frame_done <= 1'b0;
         end else if (pv_fall && frame_open && !frame_done
                      && line_cnt == lines_per_frame
                      && (!mode2 || !row_phase)) begin
            // in mode 2 only after the right row
            eof_raw    <= 1'b1;
            frame_done <= 1'b1;
         end
      end
   end

   rrs_delay_line #(
      .W     (1),
      .DEPTH (rrs_pkg::DLY_DEPTH)
   ) u_pv_delay (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_data    (pv_raw),
      .i_tap     (rrs_pkg::delay_cycles(
                     regs[rrs_pkg::IDX_SYNC_DELAY][rrs_pkg::DLY_PV_LSB +: rrs_pkg::DLY_W])),
      .o_data    (pv_dly)
   );

   // programmable delay of line and frame ends
   rrs_delay_line #(
      .W     (2),
      .DEPTH (rrs_pkg::DLY_DEPTH)
   ) u_end_delay (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_data    ({eof_raw, eol_raw}),
      .i_tap     (rrs_pkg::delay_cycles(
                     regs[rrs_pkg::IDX_SYNC_DELAY][rrs_pkg::DLY_END_LSB +: rrs_pkg::DLY_W])),
      .o_data    (end_dly)
   );

   // delayed timing outputs
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pixel_valid    <= 1'b0;
         o_line_end_pulse <= 1'b0;
         o_frame_end      <= 1'b0;
      end else begin
         o_pixel_valid    <= pv_dly;
         o_line_end_pulse <= end_dly[0];
         o_frame_end      <= end_dly[1];
      end
   end

   // counter status
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_line_count  <= '0;
         o_int_count   <= '0;
         o_pixel_count <= '0;
      end else begin
         o_line_count  <= line_cnt;
         o_int_count   <= int_cnt;
         o_pixel_count <= pixel_cnt;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_int_time_a <= '0;
         o_int_time_b <= '0;
      end else if (mode2) begin
         o_int_time_a <= 13'({int_lines, 1'b0} + 13'h0001);
         o_int_time_b <= 13'({lines_per_frame, 1'b0} + 13'h0002
                             - {int_lines, 1'b0} - 13'h0001);
      end else if (nondestructive_read) begin
         o_int_time_a <= 13'({1'b0, lines_per_frame} + 13'h0001);
         o_int_time_b <= 13'({1'b0, lines_per_frame} + 13'h0001);
      end else begin
         o_int_time_a <= 13'({1'b0, lines_per_frame} - {1'b0, int_lines} + 13'h0001);
         o_int_time_b <= 13'({1'b0, lines_per_frame} - {1'b0, int_lines} + 13'h0001);
      end
   end

   // core, window and sub-sampling settings
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_analog.core_test <= '0;
         o_analog.hsub_mode <= '0;
         o_analog.vsub_mode <= '0;
         o_analog.col_start <= '0;
         o_analog.row_start <= '0;
      end else begin
         o_analog.core_test <= core_reg[rrs_pkg::CORE_TEST_LSB +: 2];
         o_analog.hsub_mode <= core_reg[rrs_pkg::CORE_HSUB_LSB +: 3];
         o_analog.vsub_mode <= core_reg[rrs_pkg::CORE_VSUB_LSB +: 3];
         // clamp to the last column position
         o_analog.col_start <= (regs[rrs_pkg::IDX_COL_START] > rrs_pkg::COL_START_MAX)
                               ? rrs_pkg::COL_START_MAX : regs[rrs_pkg::IDX_COL_START];
         // clamp to the last row position
         o_analog.row_start <= (regs[rrs_pkg::IDX_ROW_START] > rrs_pkg::ROW_START_MAX)
                               ? rrs_pkg::ROW_START_MAX : regs[rrs_pkg::IDX_ROW_START];
      end
   end

   // amplifier and dac settings
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_analog.amp_gain            <= '0;
         o_analog.amp_unity           <= 1'b0;
         o_analog.one_output          <= 1'b0;
         o_analog.second_path_standby <= 1'b0;
         o_analog.amp_standby         <= 1'b0;
         o_analog.amp_clk_delay       <= '0;
         o_analog.amp_clk_invert      <= 1'b0;
         o_analog.coarse_dac          <= '0;
         o_analog.fine_dac            <= rrs_pkg::RST_FINE_DAC[7:0];
         o_analog.dark_dac            <= '0;
         o_analog.dark_on_reset_bus   <= 1'b0;
      end else begin
         o_analog.amp_gain  <= amp_reg[rrs_pkg::AMP_UNITY_BIT]
                               ? 4'h0 : amp_reg[rrs_pkg::AMP_GAIN_LSB +: 4];
         o_analog.amp_unity <= amp_reg[rrs_pkg::AMP_UNITY_BIT];
         // single output and second path standby
         o_analog.one_output          <= amp_reg[rrs_pkg::AMP_ONE_BIT];
         o_analog.second_path_standby <= amp_reg[rrs_pkg::AMP_ONE_BIT]
                                         | amp_reg[rrs_pkg::AMP_STBY_BIT];
         o_analog.amp_standby <= amp_reg[rrs_pkg::AMP_STBY_BIT];
         // clock delay, top code bit inverts
         o_analog.amp_clk_delay  <= amp_reg[rrs_pkg::AMP_CLKD_LSB +: 3];
         o_analog.amp_clk_invert <= amp_reg[rrs_pkg::AMP_CLKD_INV];
         o_analog.coarse_dac <= regs[rrs_pkg::IDX_COARSE_DAC][7:0];
         o_analog.fine_dac   <= regs[rrs_pkg::IDX_FINE_DAC][7:0];
         // dark level and its use on reset buses
         o_analog.dark_dac          <= regs[rrs_pkg::IDX_DARK_DAC][7:0];
         o_analog.dark_on_reset_bus <= nondestructive_read;
      end
   end

endmodule

// File: tb/rrs_ctl_model.sv
// Purpose: camera controller model making row and frame pulses
// Assumes: requests change at the falling edge
// Notes:   frame pulse held three cycles
`timescale 1ns/10ps
module rrs_ctl_model (
   input  wire logic i_sys_clk,
   input  wire logic i_frame_req,
   input  wire logic i_row_req,
   output logic      o_frame_start,
   output logic      o_row_clk
);
   logic [1:0] hold = 2'h0;
   // idle levels before the first edge
   initial begin
      o_frame_start = 1'b0;
      o_row_clk = 1'b0;
   end
   always @(negedge i_sys_clk) begin
      hold <= i_frame_req ? 2'h3 : hold - 2'(hold != 2'h0);
      o_frame_start <= i_frame_req | (hold > 2'h1);
      o_row_clk <= i_row_req;
   end
endmodule

// File: tb/rrs_sequencer_checker.sv
// Purpose: assertions on sequencer outputs
// Assumes: one clock, async low reset
// Notes:   bound to the sequencer
`timescale 1ns/10ps
module rrs_checker #(parameter int unsigned CW = 12) (
   input wire logic                 i_sys_clk,
   input wire logic                 i_rst_n,
   input wire logic                 o_line_end_pulse,
   input wire logic                 o_frame_end,
   input wire logic                 o_left_row_sync,
   input wire logic [CW-1:0]        o_line_count,
   input wire logic [CW-1:0]        o_int_count,
   input wire rrs_pkg::rrs_analog_t o_analog
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // pulses and settings
   a_eol_one_cycle: assert property (o_line_end_pulse |=> !o_line_end_pulse)
      else $error("line end long");
   a_eof_one_cycle: assert property (o_frame_end |=> !o_frame_end)
      else $error("frame end long");
   a_lsync_one_cycle: assert property (o_left_row_sync |=> !o_left_row_sync)
      else $error("left sync long");
   a_frame_clears: assert property (o_left_row_sync |-> ##[1:2]
      (o_line_count == '0 && o_int_count == '0)) else $error("counts kept");
   a_unity_gain: assert property (o_analog.amp_unity |-> o_analog.amp_gain == 4'h0)
      else $error("gain in unity");
   a_second_standby: assert property (o_analog.second_path_standby ==
      (o_analog.one_output | o_analog.amp_standby)) else $error("standby bad");
   a_clk_invert: assert property (o_analog.amp_clk_invert == o_analog.amp_clk_delay[2])
      else $error("clk invert bad");
   a_window_clamp: assert property (o_analog.col_start <= rrs_pkg::COL_START_MAX &&
      o_analog.row_start <= rrs_pkg::ROW_START_MAX) else $error("window start bad");
   c_eof: cover property (o_frame_end);
   c_eol: cover property (o_line_end_pulse);
   c_unity: cover property (o_analog.amp_unity);
endmodule
bind rrs_sequencer rrs_checker #(.CW(CW)) u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .o_line_end_pulse(o_line_end_pulse), .o_frame_end(o_frame_end),
   .o_left_row_sync(o_left_row_sync), .o_line_count(o_line_count),
   .o_int_count(o_int_count), .o_analog(o_analog));

// File: tb/test_rolling_readout_sequencer.sv
// Purpose: self-checking bench of the readout sequencer
// Assumes: short blanking for a quick run
// Notes:   random settings from a fixed xorshift seed
`timescale 1ns/10ps
module test_rolling_readout_sequencer;
   logic                 clk, rst_n, fr_req, row_req, row_clk, fs, pv, pv_q, line_end_pulse, eof, rsy;
   logic [12:0]          ta, tb;
   logic [31:0]          rs;
   logic [3:0]           dp, de;
   logic [11:0]          v, lp, rp;
   rrs_pkg::rrs_reg_wr_t wr;
   rrs_pkg::rrs_analog_t an;
   int                   errors, checked, cyc, t_up, t_dn, t_eol, n_eol, n_eof, n_rs;
   rrs_sequencer #(.BLANK_CYC(4)) dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
      .i_row_clk(row_clk), .i_frame_start(fs), .o_pixel_valid(pv), .o_line_end_pulse(line_end_pulse),
      .o_frame_end(eof), .o_left_row_sync(), .o_right_row_sync(rsy), .o_left_row_ptr(lp),
      .o_right_row_ptr(rp), .o_line_count(), .o_int_count(), .o_pixel_count(),
      .o_int_time_a(ta), .o_int_time_b(tb), .o_analog(an));
   rrs_ctl_model ctl (.i_sys_clk(clk), .i_frame_req(fr_req), .i_row_req(row_req),
      .o_frame_start(fs), .o_row_clk(row_clk));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   function automatic int dcy(input logic [3:0] c);
      return (c > 4'h2) ? int'(c) - 2 : 0;
   endfunction
   task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
      checked++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic put(input logic [3:0] a, input logic [11:0] d);
      wr <= '{1'b1, a, d};
      @(negedge clk) wr.load <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic row;
      int k;
      k = n_eol;
      row_req <= 1'b1;
      @(negedge clk) row_req <= 1'b0;
      repeat (80) if (n_eol == k) @(negedge clk);
      repeat (16) @(negedge clk);
   endtask
   task automatic frame;
      fr_req <= 1'b1;
      @(negedge clk) fr_req <= 1'b0;
      repeat (8) @(negedge clk);
      n_eof = 0;
      n_rs = 0;
   endtask
   task automatic give_verdict;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict;
   end
   // edge times of the framing outputs
   always @(negedge clk) begin
      cyc++;
      if (pv && !pv_q) t_up = cyc;
      if (!pv && pv_q) t_dn = cyc;
      if (line_end_pulse) t_eol = cyc;
      n_eol += int'(line_end_pulse);
      n_eof += int'(eof);
      n_rs += int'(rsy);
      pv_q = pv;
   end
   initial begin
      {rst_n, fr_req, row_req, pv_q, wr} = '0;
      rs = 32'd35524;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      chk("fine dac", 13'h080, an.fine_dac);
      repeat (6) begin
         rs = xs(rs);
         v = rs[11:0];
         put(rrs_pkg::IDX_AMP, v);
         chk("gain", v[4] ? 4'h0 : v[3:0], an.amp_gain);
         chk("amp standby", v[6], an.amp_standby);
         chk("one out", v[5], an.one_output);
         chk("second standby", v[5] | v[6], an.second_path_standby);
         chk("clk delay", v[9:7], an.amp_clk_delay);
         chk("clk invert", v[9], an.amp_clk_invert);
         put(rrs_pkg::IDX_COARSE_DAC, v);
         chk("coarse dac", v[7:0], an.coarse_dac);
         put(rrs_pkg::IDX_FINE_DAC, v);
         chk("fine dac wr", v[7:0], an.fine_dac);
         put(rrs_pkg::IDX_CORE, v);
         chk("core", v[7:0], {an.vsub_mode, an.hsub_mode, an.core_test});
         put(rrs_pkg::IDX_DARK_DAC, v);
         chk("dark dac", v[7:0], an.dark_dac);
      end
      put(rrs_pkg::IDX_COL_START, 12'h063);
      chk("col clamp", 13'h062, an.col_start);
      put(rrs_pkg::IDX_ROW_START, 12'h088);
      put(4'hc, 12'h000);
      chk("row start", 13'h088, an.row_start);
      put(rrs_pkg::IDX_LINES, 12'h002);
      put(rrs_pkg::IDX_INT_LINES, 12'h001);
      repeat (3) begin
         rs = xs(rs);
         dp = rs[3:0];
         de = dp | rs[7:4];
         put(rrs_pkg::IDX_PIXELS, {10'h0, rs[9:8]});
         put(rrs_pkg::IDX_SYNC_DELAY, {4'h0, de, dp});
         frame;
         chk("left load", 13'h088, lp);
         row;
         chk("right load", 13'h088, rp);
         chk("left shift", 13'h089, lp);
         chk("pv width", 2 * (rs[9:8] + 1), t_dn - t_up);
         chk("eol lag", 1 + dcy(de) - dcy(dp), t_eol - t_dn);
         chk("eof early", 0, n_eof);
         row;
         chk("eof", 1, n_eof);
         chk("right shift", 13'h089, rp);
         chk("right sync", 1, n_rs);
         chk("int time", 2, ta);
      end
      put(rrs_pkg::IDX_INT_LINES, 12'h000);
      put(rrs_pkg::IDX_SEQUENCER, 12'h001);
      chk("mode1 time", 3, tb);
      chk("dark on reset", 1, an.dark_on_reset_bus);
      put(rrs_pkg::IDX_SEQUENCER, 12'h005);
      chk("mode2 a", 1, ta);
      chk("mode2 b", 5, tb);
      put(rrs_pkg::IDX_LINES, 12'h001);
      frame;
      row;
      chk("mode2 eof early", 0, n_eof);
      row;
      chk("mode2 eof", 1, n_eof);
      give_verdict;
   end
endmodule
